// [hdl/two_wire_params.svh]
// Register offsets, bit positions, reset values and timing counts.
`ifndef TWO_WIRE_PARAMS_SVH
`define TWO_WIRE_PARAMS_SVH
`define TW_OFF_CTRL 12'h000
`define TW_OFF_STAT 12'h010
`define TW_OFF_ADDR 12'h020
`define TW_OFF_TXD 12'h050
`define TW_OFF_RXD 12'h060
`define TW_CTRL_RESET 32'h0000_1000
`define TW_C_DATA_HOLD 16
`define TW_C_ENABLE 15
`define TW_C_REL 12
`define TW_C_STRICT 11
`define TW_C_ADDR_W 10
`define TW_C_GC_EN 7
`define TW_C_STRETCH 6
`define TW_C_ACK_VAL 5
`define TW_C_ACK_REQ 4
`define TW_C_RX_REQ 3
`define TW_C_STOP_REQ 2
`define TW_C_RS_REQ 1
`define TW_C_START_REQ 0
`define TW_S_ACK_RX 15
`define TW_S_MTX 14
`define TW_S_ACK_PH 13
`define TW_S_COLL 10
`define TW_S_GC 9
`define TW_S_TEN 8
`define TW_S_WCOL 7
`define TW_S_OVF 6
`define TW_S_DATA 5
`define TW_S_STOP 4
`define TW_S_START 3
`define TW_S_READ 2
`define TW_S_RXFULL 1
`define TW_S_TXFULL 0
`define TW_CLK_NS 40
`define TW_QUARTER_NS 2500
`define TW_QUARTER_CYCLES (`TW_QUARTER_NS / `TW_CLK_NS)
`define TW_GC_ADDR 8'h00
`define TW_HDR10 5'h1e
`endif

// [hdl/two_wire_pkg.sv]
// Types shared by the two-wire control and status block.
package two_wire_pkg;
  typedef struct packed {
    logic data_hold_enable;
    logic enable;
    logic clock_release;
    logic strict;
    logic addr_width_select;
    logic general_call_enable;
    logic stretch_enable;
    logic ack_value;
    logic ack_sequence_request;
    logic master_receive_request;
    logic stop_request;
    logic restart_request;
    logic start_request;
  } ctrl_t;
  typedef struct packed {
    logic ack_received_flag;
    logic master_tx_active;
    logic ack_phase_flag;
    logic bus_collision_flag;
    logic general_call_flag;
    logic ten_bit_match_flag;
    logic write_collision_flag;
    logic receive_overflow_flag;
    logic data_not_addr;
    logic stop_seen;
    logic start_seen;
    logic read_req;
    logic rx_full;
    logic tx_full;
  } flags_t;
  typedef struct packed {
    logic ack_set;
    logic ack_clr;
    logic gc;
    logic ten;
    logic rx;
    logic tx_begin;
    logic tx_done;
    logic hold;
    logic addr;
    logic rd;
  } s_ev_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } pin_in_t;
  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } pin_drive_t;
  typedef enum logic [2:0] {M_IDLE, M_START, M_RESTART, M_STOP, M_BIT}
    m_state_t;
  typedef enum logic [1:0] {K_TX, K_RX, K_ACK} m_kind_t;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR2, S_RX, S_TX, S_WAIT}
    s_state_t;
  // Reserved 7-bit space, minus general call and the 10-bit header.
  function automatic logic reserved_addr(input logic [6:0] a);
    reserved_addr = (a[6:3] == 4'h0 && a != 7'h00) ||
                    (a[6:3] == 4'hf && a[6:2] != 5'h1e);
  endfunction
endpackage

// [hdl/two_wire_ctrl_status.sv]
// Two-wire bus master/slave sequencer with APB control and status.
// Behaviour
// [R1] Stretch on: release bit writable; hardware clears.
// [R2] Stretch off: software only sets release bit.
// [R3] Strict mode: no reserved addresses either way.
// [R4] Width bit picks 7 or 10-bit matching.
// [R5] General call enabled: match it, raise event.
// [R6] Stretch enable gates software and receive stretching.
// [R7] Ack value picks ACK or NACK level.
// [R8] Ack request runs ack slot, self-clears.
// [R9] Receive request takes one byte, self-clears.
// [R10] Stop request makes Stop, self-clears.
// [R11] Restart request makes Repeated Start, self-clears.
// [R12] Start request makes Start, self-clears.
// [R13] Ack flag records slave reply after transmit.
// [R14] Master transmit flag spans eight bits plus ack.
// [R15] Slave ack phase: eighth fall to ninth rise.
// [R16] Master collision sets sticky collision flag.
// [R17] General call flag set on match, Stop clears.
// [R18] Ten-bit flag on second byte, Stop clears.
// [R19] Transmit write while busy fails, flags collision.
// [R20] Receive load onto unread byte flags overflow.
// [R21] Status upper bits and 12:11 read zero.
// [R22] Enable bit hands pins to the block.
// [R23] Data hold stretches after received data byte.
// [R24] Software issues one sequence request at once.
`timescale 1ns/1ps
`include "two_wire_params.svh"
module two_wire_ctrl_status #(
  parameter int QUARTER_CYCLES = `TW_QUARTER_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input two_wire_pkg::pin_in_t pins_in,
  output two_wire_pkg::pin_drive_t pins_drive,
  output logic pins_owned,
  output logic slave_event
);
  import two_wire_pkg::*;

  // The divider counter is twelve bits wide, so values above 4095 cannot work.
  if (QUARTER_CYCLES < 1 || QUARTER_CYCLES > 4095) begin : g_bad_div
    $error("QUARTER_CYCLES must lie between 1 and 4095.");
  end

  ctrl_t ctrl_q, ctrl_d;
  flags_t flags_q, flags_d;
  s_ev_t s_ev_q;
  m_state_t m_state_q;
  m_kind_t m_kind_q;
  s_state_t s_state_q, s_next_q;
  logic [1:0] m_phase_q;
  logic [3:0] m_bit_q, s_cnt_q;
  logic [7:0] m_shift_q, s_shift_q, trn_q, rcv_q;
  logic [9:0] own_q;
  logic [11:0] div_q;
  logic m_scl_low_q, m_sda_low_q, owner_q, first_q;
  logic s_ack_low_q, s_nack_q, s_hold_low_q;
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  pin_drive_t drive_q;
  logic owned_q, event_q;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pins_drive = drive_q;
  assign pins_owned = owned_q;
  assign slave_event = event_q;

  // Pins come from another domain; two flops before use, a third for edges.
  always_ff @(posedge ref_clk) begin
    {scl_m, scl_s, scl_p} <= {pins_in.scl, scl_m, scl_s};
    {sda_m, sda_s, sda_p} <= {pins_in.sda, sda_m, sda_s};
  end

  wire scl_rise = scl_s && !scl_p;
  wire scl_fall = !scl_s && scl_p;
  wire start_det = scl_s && scl_p && sda_p && !sda_s;
  wire stop_det = scl_s && scl_p && !sda_p && sda_s;

  // APB decode; every access gets one wait state so data is registered.
  wire acc = psel && penable;
  wire done = acc && pready_q;
  wire sel_ctrl = paddr == `TW_OFF_CTRL;
  wire sel_stat = paddr == `TW_OFF_STAT;
  wire sel_addr = paddr == `TW_OFF_ADDR;
  wire sel_txd = paddr == `TW_OFF_TXD;
  wire sel_rxd = paddr == `TW_OFF_RXD;
  wire mapped = sel_ctrl || sel_stat || sel_addr || sel_txd || sel_rxd;
  wire wr_ctrl = done && pwrite && sel_ctrl;
  wire wr_stat = done && pwrite && sel_stat;
  wire wr_addr = done && pwrite && sel_addr;
  wire wr_txd = done && pwrite && sel_txd;
  wire rd_rxd = done && !pwrite && sel_rxd;

  // Status word; bits above 15 and bits 12:11 stay zero. [R21]
  wire [31:0] stat_word = {16'h0000, flags_q.ack_received_flag,
    flags_q.master_tx_active, flags_q.ack_phase_flag, 2'b00,
    flags_q.bus_collision_flag, flags_q.general_call_flag,
    flags_q.ten_bit_match_flag, flags_q.write_collision_flag,
    flags_q.receive_overflow_flag, flags_q.data_not_addr,
    flags_q.stop_seen, flags_q.start_seen, flags_q.read_req,
    flags_q.rx_full, flags_q.tx_full};
  wire [31:0] ctrl_word = {15'h0, ctrl_q.data_hold_enable,
    ctrl_q.enable, 2'b00, ctrl_q.clock_release, ctrl_q.strict,
    ctrl_q.addr_width_select, 2'b00, ctrl_q.general_call_enable,
    ctrl_q.stretch_enable, ctrl_q.ack_value, ctrl_q.ack_sequence_request,
    ctrl_q.master_receive_request, ctrl_q.stop_request,
    ctrl_q.restart_request, ctrl_q.start_request};
  wire [31:0] rd_word = sel_ctrl ? ctrl_word :
                        sel_stat ? stat_word :
                        sel_addr ? {22'h0, own_q} :
                        sel_txd ? {24'h000000, trn_q} :
                        sel_rxd ? {24'h000000, rcv_q} : 32'h0000_0000;

  // Read data and error are captured in the cycle pready rises.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !mapped;
      prdata_q <= (acc && !pready_q && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Master sequencing decode; requests are one at a time by contract. [R24]
  wire m_req_any = ctrl_q.start_request || ctrl_q.restart_request ||
    ctrl_q.stop_request || ctrl_q.master_receive_request ||
    ctrl_q.ack_sequence_request;
  wire m_idle = m_state_q == M_IDLE;
  wire m_tx_begin = ctrl_q.enable && m_idle && !m_req_any && owner_q &&
    flags_q.tx_full;
  wire m_tick = div_q == 12'(QUARTER_CYCLES - 1);
  wire m_step = m_tick && !m_idle && (m_phase_q != 2'd2 || scl_s);
  wire m_last = (m_kind_q == K_TX) ? (m_bit_q == 4'd8) :
                (m_kind_q == K_RX) ? (m_bit_q == 4'd7) : 1'b1;
  wire m_fin = m_step && m_phase_q == 2'd3 &&
    (m_state_q != M_BIT || m_last);
  wire m_tx_fin = m_fin && m_state_q == M_BIT && m_kind_q == K_TX;
  wire m_rx_fin = m_fin && m_state_q == M_BIT && m_kind_q == K_RX;
  wire m_seq_fin = m_fin && !m_tx_fin;
  wire coll_bit = m_state_q == M_BIT && m_kind_q == K_TX &&
    m_bit_q < 4'd8 && !m_sda_low_q && !sda_s;
  // A released line that reads low means another master owns it. [R16]
  wire m_abort = m_step && (
    (m_state_q == M_START && m_phase_q == 2'd1 && (!sda_s || !scl_s)) ||
    (m_state_q == M_RESTART && m_phase_q == 2'd2 && !sda_s) ||
    (m_phase_q == 2'd2 && coll_bit));
  wire m_drive = (m_kind_q == K_TX) ? (m_bit_q < 4'd8 && !m_shift_q[7]) :
                 (m_kind_q == K_ACK) ? !ctrl_q.ack_value : 1'b0;  // [R7]
  wire m_busy = !m_idle || m_req_any || flags_q.tx_full;
  wire tx_refused = m_busy ||
    (ctrl_q.strict && first_q && reserved_addr(pwdata[7:1]));  // [R3]

  // Quarter-bit divider for the master's own clock.
  always_ff @(posedge ref_clk) begin
    if (rst || m_tick) div_q <= 12'h000;
    else div_q <= div_q + 12'h001;
  end

  // Master sequencer: four quarter phases per condition or bit.
  always_ff @(posedge ref_clk) begin
    if (rst || !ctrl_q.enable || m_abort) begin
      m_state_q <= M_IDLE;
      m_kind_q <= K_TX;
      m_phase_q <= 2'd0;
      m_bit_q <= 4'h0;
      m_scl_low_q <= 1'b0;
      m_sda_low_q <= 1'b0;
    end else if (m_idle) begin
      m_phase_q <= 2'd0;
      m_bit_q <= 4'h0;
      if (ctrl_q.start_request) m_state_q <= M_START;  // [R12]
      else if (ctrl_q.restart_request) m_state_q <= M_RESTART;  // [R11]
      else if (ctrl_q.stop_request) m_state_q <= M_STOP;  // [R10]
      else if (ctrl_q.master_receive_request || ctrl_q.ack_sequence_request
          || m_tx_begin) begin
        m_state_q <= M_BIT;
        m_kind_q <= ctrl_q.master_receive_request ? K_RX :
                    ctrl_q.ack_sequence_request ? K_ACK : K_TX;  // [R8] [R9]
        m_shift_q <= trn_q;
      end
    end else if (m_step) begin
      m_phase_q <= m_phase_q + 2'd1;
      case (m_state_q)
        M_START: begin
          if (m_phase_q == 2'd0) {m_scl_low_q, m_sda_low_q} <= 2'b00;
          if (m_phase_q == 2'd1) m_sda_low_q <= 1'b1;
          if (m_phase_q == 2'd2) m_scl_low_q <= 1'b1;
        end
        M_RESTART: begin
          if (m_phase_q == 2'd0) m_sda_low_q <= 1'b0;
          if (m_phase_q == 2'd1) m_scl_low_q <= 1'b0;
          if (m_phase_q == 2'd2) m_sda_low_q <= 1'b1;
          if (m_phase_q == 2'd3) m_scl_low_q <= 1'b1;
        end
        M_STOP: begin
          if (m_phase_q == 2'd0) m_sda_low_q <= 1'b1;
          if (m_phase_q == 2'd1) m_scl_low_q <= 1'b0;
          if (m_phase_q == 2'd2) m_sda_low_q <= 1'b0;
        end
        M_BIT: begin
          if (m_phase_q == 2'd0) m_sda_low_q <= m_drive;
          if (m_phase_q == 2'd1) m_scl_low_q <= 1'b0;
          if (m_phase_q == 2'd2) m_shift_q <= {m_shift_q[6:0], sda_s};
          if (m_phase_q == 2'd3) begin
            m_scl_low_q <= 1'b1;
            m_bit_q <= m_bit_q + 4'h1;
          end
        end
        default: m_state_q <= M_IDLE;
      endcase
      if (m_fin) m_state_q <= M_IDLE;
    end
  end

  // Bus ownership runs from our Start to our Stop; first byte is address.
  always_ff @(posedge ref_clk) begin
    if (rst || !ctrl_q.enable || m_abort) begin
      owner_q <= 1'b0;
      first_q <= 1'b0;
    end else if (m_fin && m_state_q == M_STOP) begin
      owner_q <= 1'b0;
      first_q <= 1'b0;
    end else if (m_fin && m_state_q != M_BIT) begin
      owner_q <= 1'b1;
      first_q <= 1'b1;
    end else if (m_tx_begin) begin
      first_q <= 1'b0;
    end
  end

  // Slave address decode on the byte in the shifter.
  wire gc_hit = s_shift_q == `TW_GC_ADDR && ctrl_q.general_call_enable;
  wire hit7 = !ctrl_q.addr_width_select && s_shift_q[7:1] == own_q[6:0] &&
    !(ctrl_q.strict && reserved_addr(s_shift_q[7:1]));  // [R3] [R4]
  wire hit_hdr = ctrl_q.addr_width_select &&
    s_shift_q[7:3] == `TW_HDR10 && s_shift_q[2:1] == own_q[9:8] &&
    (!s_shift_q[0] || flags_q.ten_bit_match_flag);  // [R4]
  wire hit_lo = s_shift_q == own_q[7:0];
  wire s_rx_state = s_state_q == S_ADDR || s_state_q == S_ADDR2 ||
    s_state_q == S_RX;
  wire s_live = s_state_q != S_IDLE && s_state_q != S_WAIT;
  wire s_drive = (s_state_q == S_TX && s_cnt_q < 4'd8) ? !s_shift_q[7] :
    s_ack_low_q;

  // Slave receiver and transmitter, stepped by the sampled bus clock.
  always_ff @(posedge ref_clk) begin
    s_ev_q <= '0;
    if (rst || !ctrl_q.enable || stop_det) begin
      s_state_q <= S_IDLE;
      s_next_q <= S_IDLE;
      s_cnt_q <= 4'h0;
      s_ack_low_q <= 1'b0;
      s_nack_q <= 1'b0;
      s_shift_q <= 8'h00;
    end else if (start_det && !owner_q && m_idle) begin
      s_state_q <= S_ADDR;
      s_cnt_q <= 4'hf;  // The Start's own clock fall wraps this to zero.
      s_ack_low_q <= 1'b0;
    end else if (s_state_q != S_IDLE) begin
      // Reload until the first bit goes out, so a late write still counts.
      if (s_state_q == S_TX && s_cnt_q == 4'h0 && !scl_s)
        s_shift_q <= trn_q;
      if (scl_rise) begin
        if (s_rx_state && s_cnt_q < 4'd8)
          s_shift_q <= {s_shift_q[6:0], sda_s};
        if (s_cnt_q == 4'd8) begin
          s_ev_q.ack_clr <= s_live;  // [R15]
          s_nack_q <= sda_s;
        end
      end else if (scl_fall && s_cnt_q == 4'd7) begin
        s_cnt_q <= 4'd8;
        s_ev_q.ack_set <= s_live;  // [R15]
        s_next_q <= S_WAIT;
        case (s_state_q)
          S_ADDR: begin
            s_ack_low_q <= gc_hit || hit7 || hit_hdr;
            s_ev_q.gc <= gc_hit;  // [R5]
            s_ev_q.addr <= hit7 || hit_hdr;
            s_ev_q.rd <= s_shift_q[0];
            if (gc_hit) s_next_q <= S_RX;
            else if ((hit7 || hit_hdr) && s_shift_q[0]) s_next_q <= S_TX;
            else if (hit7) s_next_q <= S_RX;
            else if (hit_hdr) s_next_q <= S_ADDR2;
          end
          S_ADDR2: begin
            s_ack_low_q <= hit_lo;
            s_ev_q.ten <= hit_lo;  // [R18]
            if (hit_lo) s_next_q <= S_RX;
          end
          S_RX: begin
            s_ack_low_q <= !flags_q.rx_full;
            s_ev_q.rx <= 1'b1;
            s_ev_q.hold <= ctrl_q.stretch_enable ||
              ctrl_q.data_hold_enable;  // [R1] [R6] [R23]
            s_next_q <= S_RX;
          end
          S_TX: s_next_q <= S_TX;
          default: s_next_q <= S_WAIT;
        endcase
      end else if (scl_fall && s_cnt_q == 4'd8) begin
        s_cnt_q <= 4'h0;
        s_ack_low_q <= 1'b0;
        if (s_state_q == S_TX) begin
          s_ev_q.tx_done <= 1'b1;
          s_state_q <= s_nack_q ? S_WAIT : S_TX;
          s_ev_q.tx_begin <= !s_nack_q;  // [R1] [R2]
        end else begin
          s_state_q <= s_next_q;
          s_ev_q.tx_begin <= s_next_q == S_TX;  // [R1] [R2]
        end
      end else if (scl_fall && s_live) begin
        s_cnt_q <= s_cnt_q + 4'h1;
        if (s_state_q == S_TX) s_shift_q <= {s_shift_q[6:0], 1'b0};
      end
    end
  end

  // Hold the clock only once it is already low, never mid high-time.
  always_ff @(posedge ref_clk) begin
    if (rst) s_hold_low_q <= 1'b0;
    else s_hold_low_q <= ctrl_q.enable && s_live &&
      !ctrl_q.clock_release && (s_hold_low_q || !scl_s);  // [R6]
  end

  // Control register: software writes, hardware clears requests.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.data_hold_enable = pwdata[`TW_C_DATA_HOLD];
      ctrl_d.enable = pwdata[`TW_C_ENABLE];  // [R22]
      ctrl_d.strict = pwdata[`TW_C_STRICT];
      ctrl_d.addr_width_select = pwdata[`TW_C_ADDR_W];
      ctrl_d.general_call_enable = pwdata[`TW_C_GC_EN];
      ctrl_d.stretch_enable = pwdata[`TW_C_STRETCH];
      ctrl_d.ack_value = pwdata[`TW_C_ACK_VAL];
      ctrl_d.ack_sequence_request = pwdata[`TW_C_ACK_REQ];
      ctrl_d.master_receive_request = pwdata[`TW_C_RX_REQ];
      ctrl_d.stop_request = pwdata[`TW_C_STOP_REQ];
      ctrl_d.restart_request = pwdata[`TW_C_RS_REQ];
      ctrl_d.start_request = pwdata[`TW_C_START_REQ];
      if (ctrl_q.stretch_enable)
        ctrl_d.clock_release = pwdata[`TW_C_REL];  // [R1]
      else
        ctrl_d.clock_release = ctrl_q.clock_release | pwdata[`TW_C_REL];  // [R2]
    end
    // Hardware clear is applied last; a stretch point beats a release.
    if (s_ev_q.tx_begin || s_ev_q.hold)
      ctrl_d.clock_release = 1'b0;  // [R1] [R2] [R23]
    if (m_seq_fin || m_abort) begin
      ctrl_d.start_request = 1'b0;  // [R12]
      ctrl_d.restart_request = 1'b0;  // [R11]
      ctrl_d.stop_request = 1'b0;  // [R10]
      ctrl_d.master_receive_request = 1'b0;  // [R9]
      ctrl_d.ack_sequence_request = 1'b0;  // [R8]
    end
  end

  // Status flags: software clears first, hardware sets win.
  always_comb begin
    flags_d = flags_q;
    if (wr_stat) begin
      flags_d.ack_phase_flag &= pwdata[`TW_S_ACK_PH];
      flags_d.bus_collision_flag &= pwdata[`TW_S_COLL];
      flags_d.write_collision_flag &= pwdata[`TW_S_WCOL];
      flags_d.receive_overflow_flag &= pwdata[`TW_S_OVF];
      flags_d.stop_seen &= pwdata[`TW_S_STOP];
      flags_d.start_seen &= pwdata[`TW_S_START];
    end
    if (m_tx_begin) flags_d.master_tx_active = 1'b1;  // [R14]
    if (m_tx_fin) begin
      flags_d.ack_received_flag = m_shift_q[0];  // [R13]
      flags_d.master_tx_active = 1'b0;  // [R14]
    end
    if (m_abort) begin
      flags_d.master_tx_active = 1'b0;
      flags_d.tx_full = 1'b0;
      flags_d.bus_collision_flag = 1'b1;  // [R16]
    end
    if (s_ev_q.ack_clr) flags_d.ack_phase_flag = 1'b0;  // [R15]
    if (s_ev_q.ack_set) flags_d.ack_phase_flag = 1'b1;  // [R15]
    if (stop_det) begin
      flags_d.general_call_flag = 1'b0;  // [R17]
      flags_d.ten_bit_match_flag = 1'b0;  // [R18]
      flags_d.stop_seen = 1'b1;
      flags_d.start_seen = 1'b0;
    end
    if (start_det) begin
      flags_d.start_seen = 1'b1;
      flags_d.stop_seen = 1'b0;
    end
    if (s_ev_q.gc) flags_d.general_call_flag = 1'b1;  // [R17]
    if (s_ev_q.ten) flags_d.ten_bit_match_flag = 1'b1;  // [R18]
    if (s_ev_q.addr || s_ev_q.gc) begin
      flags_d.data_not_addr = 1'b0;
      flags_d.read_req = s_ev_q.rd;
    end
    if (s_ev_q.rx) flags_d.data_not_addr = 1'b1;
    if (rd_rxd) flags_d.rx_full = 1'b0;
    if (m_rx_fin || s_ev_q.rx) begin
      if (flags_q.rx_full) flags_d.receive_overflow_flag = 1'b1;  // [R20]
      else flags_d.rx_full = 1'b1;
    end
    if (m_tx_fin || s_ev_q.tx_done) flags_d.tx_full = 1'b0;
    if (wr_txd) begin
      if (tx_refused) flags_d.write_collision_flag = 1'b1;  // [R19]
      else flags_d.tx_full = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Struct order is not register order; take the release bit alone.
      ctrl_q <= '0;
      ctrl_q.clock_release <= 1'(`TW_CTRL_RESET >> `TW_C_REL);
      flags_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      flags_q <= flags_d;
    end
  end

  // Data registers; an overflowing byte is dropped, the old one kept.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      own_q <= 10'h000;
      trn_q <= 8'h00;
      rcv_q <= 8'h00;
    end else begin
      if (wr_addr) own_q <= pwdata[9:0];
      if (wr_txd && !tx_refused) trn_q <= pwdata[7:0];  // [R19]
      if (m_rx_fin && !flags_q.rx_full) rcv_q <= m_shift_q;  // [R20]
      else if (s_ev_q.rx && !flags_q.rx_full) rcv_q <= s_shift_q;
    end
  end

  // Open-drain pins: only ever pull low, released while disabled.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drive_q <= '0;
      owned_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      drive_q.scl_oe <= ctrl_q.enable && (m_scl_low_q || s_hold_low_q);
      drive_q.sda_oe <= ctrl_q.enable && (m_sda_low_q || s_drive);
      owned_q <= ctrl_q.enable;  // [R22]
      event_q <= s_ev_q.gc || s_ev_q.addr || s_ev_q.ten;  // [R5]
    end
  end
endmodule // two_wire_ctrl_status

// [sim/two_wire_ctrl_status_checker.sv]
// Port-level assertions for the two-wire control and status block.
`timescale 1ns/1ps
module two_wire_ctrl_status_checker #(
  parameter int QUARTER_CYCLES = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input two_wire_pkg::pin_in_t pins_in,
  input two_wire_pkg::pin_drive_t pins_drive,
  input wire logic pins_owned,
  input wire logic slave_event
);
  import two_wire_pkg::*;
  // Pin sync adds a few clocks to two quarters, the bound for pulling the clock line.
  localparam int START_MAX = 2 * QUARTER_CYCLES + 4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence setup_then_access;
    psel && !penable ##1 psel && penable;
  endsequence
  // Start: data line pulled while clock high, then clock pulled.
  sequence start_edge;
    $rose(pins_drive.sda_oe) && !pins_drive.scl_oe && pins_in.scl;
  endsequence
  a_one_wait: assert property (setup_then_access |=> pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  a_stat_zero: assert property (
    pready && !pwrite && paddr == 12'h010 |->
    prdata[31:16] == 16'h0 && prdata[12:11] == 2'h0)
    else $error("status reserved bits nonzero");
  a_gpio_release: assert property (
    !pins_owned |-> !pins_drive.scl_oe && !pins_drive.sda_oe)
    else $error("pins driven while not owned");
  a_open_drain: assert property (
    pins_drive.scl_out == 1'b0 && pins_drive.sda_out == 1'b0)
    else $error("pin driven high");
  a_start_order: assert property (
    start_edge |-> pins_drive.sda_oe throughout
    ##[1:START_MAX] pins_drive.scl_oe)
    else $error("start condition malformed");
endmodule // two_wire_ctrl_status_checker
bind two_wire_ctrl_status two_wire_ctrl_status_checker #(
  .QUARTER_CYCLES(QUARTER_CYCLES)) two_wire_ctrl_status_checker_inst (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
  .pins_drive(pins_drive), .pins_owned(pins_owned),
  .slave_event(slave_event));

// [sim/bus_partner.sv]
// Far-side slave on the two-wire bus: answers the ack slot of each byte.
`timescale 1ns/1ps
module bus_partner (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  output logic sda_low
);
  int edges = 0;
  initial sda_low = 1'b0;
  // A Start or repeated Start restarts the count of clock falls.
  always @(negedge sda) if (scl) edges = 0;
  // The Start's own fall counts too, so the ack slot opens at fall nine.
  always @(negedge scl) begin
    edges = edges + 1;
    if (edges == 9) sda_low <= !nack;
    if (edges == 10) begin
      sda_low <= 1'b0;
      edges = 1;
    end
  end
endmodule // bus_partner

// [sim/two_wire_ctrl_status_tb_top.sv]
// Self-checking bench for the two-wire control and status block.
`timescale 1ns/1ps
module two_wire_ctrl_status_tb_top;
  import two_wire_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pins_owned, slave_event, sda_low, last_err;
  logic nack = 1'b0;
  pin_in_t pins_in;
  pin_drive_t pins_drive;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  // Open-drain lines: low while any party pulls, else the pull-up wins.
  assign pins_in.scl = !pins_drive.scl_oe;
  assign pins_in.sda = !(pins_drive.sda_oe || sda_low);
  always #20 ref_clk = ~ref_clk;
  // A short quarter keeps each bus bit at 400 ns, five quarters with the wait for the clock line to read high.
  two_wire_ctrl_status #(.QUARTER_CYCLES(2)) two_wire_ctrl_status_inst (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
    .pins_drive(pins_drive), .pins_owned(pins_owned),
    .slave_event(slave_event));
  bus_partner bus_partner_inst (.scl(pins_in.scl), .sda(pins_in.sda),
    .nack(nack), .sda_low(sda_low));
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input logic [11:0] a, input int b);
    do apb(1'b0, a, 32'h0); while (rd[b] !== 1'b0);
  endtask
  task automatic test_reset();
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_1000);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    $display("test_reset done");
  endtask
  task automatic test_release();
    apb(1'b1, 12'h000, 32'h0000_8000);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_9000);
    apb(1'b1, 12'h000, 32'h0000_9040);
    apb(1'b1, 12'h000, 32'h0000_8040);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_8040);
    apb(1'b1, 12'h000, 32'h0000_9000);
    $display("test_release done");
  endtask
  // Send one byte; the partner answers with the given ack level.
  task automatic send(input logic [7:0] b, input logic n);
    nack <= n;
    apb(1'b1, 12'h050, {24'h0, b});
    apb(1'b1, 12'h050, 32'h0000_0066);
    apb(1'b0, 12'h010, 32'h0);
    chk({30'h0, rd[14], rd[7]}, 32'h3);
    poll(12'h010, 14);
    chk({31'h0, rd[15]}, {31'h0, n});
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, rd[7]}, 32'h0);
  endtask
  task automatic test_master();
    apb(1'b1, 12'h000, 32'h0000_9001);
    poll(12'h000, 0);
    chk({31'h0, pins_owned}, 32'h1);
    send(8'ha5, 1'b0);
    send(8'h3c, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_9002);
    poll(12'h000, 1);
    apb(1'b1, 12'h000, 32'h0000_9008);
    poll(12'h000, 3);
    apb(1'b0, 12'h060, 32'h0);
    chk(rd, 32'h0000_00ff);
    apb(1'b1, 12'h000, 32'h0000_9030);
    poll(12'h000, 4);
    apb(1'b1, 12'h000, 32'h0000_9004);
    poll(12'h000, 2);
    chk({30'h0, pins_in}, 32'h3);
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, pins_owned}, 32'h0);
    $display("test_master done");
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_release();
    test_master();
    conclude();
  end
endmodule // two_wire_ctrl_status_tb_top
